// *** rtl/rtd_datapath_regs.sv ***
module rtd_datapath_regs #(
  parameter int RX_W = 12,
  parameter int TX_W = 12
) (
  input wire logic clock,
  input wire logic srst,
  input wire logic reg_write,
  input wire logic reg_read,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  output logic reg_rvalid,
  input wire logic signed [RX_W-1:0] i_input_converter,
  input wire logic signed [RX_W-1:0] q_input_converter,
  output logic signed [RX_W+2:0] rx_i_data,
  output logic signed [RX_W+2:0] rx_q_data,
  output logic signed [RX_W+2:0] rx_single_data,
  input wire logic signed [TX_W-1:0] tx_i_sample,
  input wire logic signed [TX_W-1:0] tx_q_sample,
  output logic signed [TX_W+2:0] i_output_converter,
  output logic signed [TX_W+2:0] q_output_converter,
  output logic rx_doubler_reset,
  output logic tx_doubler_reset,
  output logic rx_doubler_type,
  output logic tx_doubler_type,
  output logic [7:0] tx_doubler_tuning,
  output logic [7:0] rx_doubler_tuning,
  output logic [7:0] doubler_start_tap,
  output logic [2:0] tx_doubler_pulse,
  output logic [2:0] rx_doubler_pulse,
  output logic single_receive_path,
  output logic rx_clock_from_i,
  input wire logic full_duplex,
  input wire logic half_duplex_clock_submode,
  input wire logic tx_clock_source,
  output logic transmit_clock_pin_out,
  output logic transmit_clock_pin_oe
);
  logic [7:0] rx_gain_scale_reg;
  logic [7:0] doubler_reset_and_type_reg;
  logic [7:0] tx_doubler_tuning_reg;
  logic [7:0] rx_doubler_tuning_reg;
  logic [7:0] doubler_initial_tap_reg;
  logic [7:0] iq_spectral_invert_reg;
  logic [7:0] doubler_pulse_width_reg;
  logic [7:0] rx_interface_config_reg;
  logic [7:0] rdata_next;
  logic [7:0] wmasked;
  logic signed [RX_W+2:0] lane_rx_i;
  logic signed [RX_W+2:0] lane_rx_q;
  logic signed [TX_W+2:0] lane_tx_i;
  logic signed [TX_W+2:0] lane_tx_q;
  logic hd_single_clock;

  initial
  begin
    if (RX_W < 2 || TX_W < 2)
      $error("rtd_datapath_regs: sample width must be at least 2");
  end

  // writable bits per address; unmapped addresses give zero
  function automatic logic [7:0] reg_mask(input logic [7:0] addr);
    case (addr)
      rtd_pkg::ADDR_RX_GAIN: reg_mask = rtd_pkg::MASK_RX_GAIN;
      rtd_pkg::ADDR_DBL_CTRL: reg_mask = rtd_pkg::MASK_DBL_CTRL;
      rtd_pkg::ADDR_TX_TUNE: reg_mask = rtd_pkg::MASK_TUNE;
      rtd_pkg::ADDR_RX_TUNE: reg_mask = rtd_pkg::MASK_TUNE;
      rtd_pkg::ADDR_START_TAP: reg_mask = rtd_pkg::MASK_START_TAP;
      rtd_pkg::ADDR_INVERT: reg_mask = rtd_pkg::MASK_INVERT;
      rtd_pkg::ADDR_PULSE: reg_mask = rtd_pkg::MASK_PULSE;
      rtd_pkg::ADDR_RX_IF: reg_mask = rtd_pkg::MASK_RX_IF;
      default: reg_mask = 8'h00;
    endcase
  endfunction : reg_mask

  assign wmasked = reg_wdata & reg_mask(reg_addr);

  always_ff @(posedge clock)
  begin
    if (srst)
    begin
      rx_gain_scale_reg <= rtd_pkg::RESET_VALUE;
      doubler_reset_and_type_reg <= rtd_pkg::RESET_VALUE;
      tx_doubler_tuning_reg <= rtd_pkg::RESET_VALUE;
      rx_doubler_tuning_reg <= rtd_pkg::RESET_VALUE;
      doubler_initial_tap_reg <= rtd_pkg::RESET_VALUE;
      iq_spectral_invert_reg <= rtd_pkg::RESET_VALUE;
      doubler_pulse_width_reg <= rtd_pkg::RESET_VALUE;
      rx_interface_config_reg <= rtd_pkg::RESET_VALUE;
    end
    else if (reg_write)
    begin
      case (reg_addr)
        rtd_pkg::ADDR_RX_GAIN: rx_gain_scale_reg <= wmasked;
        rtd_pkg::ADDR_DBL_CTRL: doubler_reset_and_type_reg <= wmasked;
        rtd_pkg::ADDR_TX_TUNE: tx_doubler_tuning_reg <= wmasked;
        rtd_pkg::ADDR_RX_TUNE: rx_doubler_tuning_reg <= wmasked;
        rtd_pkg::ADDR_START_TAP: doubler_initial_tap_reg <= wmasked;
        rtd_pkg::ADDR_INVERT: iq_spectral_invert_reg <= wmasked;
        rtd_pkg::ADDR_PULSE: doubler_pulse_width_reg <= wmasked;
        rtd_pkg::ADDR_RX_IF: rx_interface_config_reg <= wmasked;
        default: ;
      endcase
    end
  end

  always_comb
  begin
    case (reg_addr)
      rtd_pkg::ADDR_RX_GAIN: rdata_next = rx_gain_scale_reg;
      rtd_pkg::ADDR_DBL_CTRL: rdata_next = doubler_reset_and_type_reg;
      rtd_pkg::ADDR_TX_TUNE: rdata_next = tx_doubler_tuning_reg;
      rtd_pkg::ADDR_RX_TUNE: rdata_next = rx_doubler_tuning_reg;
      rtd_pkg::ADDR_START_TAP: rdata_next = doubler_initial_tap_reg;
      rtd_pkg::ADDR_INVERT: rdata_next = iq_spectral_invert_reg;
      rtd_pkg::ADDR_PULSE: rdata_next = doubler_pulse_width_reg;
      rtd_pkg::ADDR_RX_IF: rdata_next = rx_interface_config_reg;
      default: rdata_next = 8'h00;
    endcase
  end

  always_ff @(posedge clock)
  begin
    if (srst)
    begin
      reg_rdata <= 8'h00;
      reg_rvalid <= 1'b0;
    end
    else
    begin
      reg_rvalid <= reg_read;
      reg_rdata <= reg_read ? rdata_next : 8'h00;
    end
  end

  // doubler controls leave through flops, one cycle after the write
  always_ff @(posedge clock)
  begin
    if (srst)
    begin
      rx_doubler_reset <= 1'b0;
      tx_doubler_reset <= 1'b0;
      rx_doubler_type <= 1'b0;
      tx_doubler_type <= 1'b0;
      tx_doubler_tuning <= 8'h00;
      rx_doubler_tuning <= 8'h00;
      doubler_start_tap <= 8'h00;
      tx_doubler_pulse <= 3'h0;
      rx_doubler_pulse <= 3'h0;
    end
    else
    begin
      // reset is held for as long as software leaves the bit set
      rx_doubler_reset <=
        doubler_reset_and_type_reg[rtd_pkg::BIT_RX_DBL_RST];
      tx_doubler_reset <=
        doubler_reset_and_type_reg[rtd_pkg::BIT_TX_DBL_RST];
      rx_doubler_type <=
        doubler_reset_and_type_reg[rtd_pkg::BIT_RX_DBL_TYPE];
      tx_doubler_type <=
        doubler_reset_and_type_reg[rtd_pkg::BIT_TX_DBL_TYPE];
      // tuning passed through as is; values are software's duty
      tx_doubler_tuning <= tx_doubler_tuning_reg;
      rx_doubler_tuning <= rx_doubler_tuning_reg;
      doubler_start_tap <= doubler_initial_tap_reg;
      tx_doubler_pulse <= doubler_pulse_width_reg
        [rtd_pkg::TX_PULSE_HI:rtd_pkg::TX_PULSE_LO];
      rx_doubler_pulse <= doubler_pulse_width_reg
        [rtd_pkg::RX_PULSE_HI:rtd_pkg::RX_PULSE_LO];
    end
  end

  rtd_lane #(
    .IN_W(RX_W),
    .OUT_W(RX_W + 3)
  ) u_rx_i (
    .clock(clock),
    .srst(srst),
    .sample(i_input_converter),
    .negate(iq_spectral_invert_reg[rtd_pkg::BIT_RX_I_NEG]),
    .gain_code(rx_gain_scale_reg[rtd_pkg::GAIN_W-1:0]),
    .result(lane_rx_i)
  );

  rtd_lane #(
    .IN_W(RX_W),
    .OUT_W(RX_W + 3)
  ) u_rx_q (
    .clock(clock),
    .srst(srst),
    .sample(q_input_converter),
    .negate(iq_spectral_invert_reg[rtd_pkg::BIT_RX_Q_NEG]),
    .gain_code(rx_gain_scale_reg[rtd_pkg::GAIN_W-1:0]),
    .result(lane_rx_q)
  );

  // tx reuses the lane at unity gain, so only the negation changes the sample
  rtd_lane #(
    .IN_W(TX_W),
    .OUT_W(TX_W + 3)
  ) u_tx_i (
    .clock(clock),
    .srst(srst),
    .sample(tx_i_sample),
    .negate(iq_spectral_invert_reg[rtd_pkg::BIT_TX_I_NEG]),
    .gain_code(rtd_pkg::UNITY_GAIN),
    .result(lane_tx_i)
  );

  rtd_lane #(
    .IN_W(TX_W),
    .OUT_W(TX_W + 3)
  ) u_tx_q (
    .clock(clock),
    .srst(srst),
    .sample(tx_q_sample),
    .negate(iq_spectral_invert_reg[rtd_pkg::BIT_TX_Q_NEG]),
    .gain_code(rtd_pkg::UNITY_GAIN),
    .result(lane_tx_q)
  );

  assign rx_i_data = lane_rx_i;
  assign rx_q_data = lane_rx_q;
  assign i_output_converter = lane_tx_i;
  assign q_output_converter = lane_tx_q;

  // single path output; lags the lanes by one cycle
  always_ff @(posedge clock)
  begin
    if (srst)
    begin
      rx_single_data <= '0;
      single_receive_path <= 1'b0;
      rx_clock_from_i <= 1'b0;
    end
    else
    begin
      single_receive_path <=
        rx_interface_config_reg[rtd_pkg::BIT_SINGLE];
      if (rx_interface_config_reg[rtd_pkg::BIT_BUS_SEL])
        rx_single_data <= lane_rx_i;
      else
        rx_single_data <= lane_rx_q;
      // clock choice only matters while a single path is in use
      rx_clock_from_i <= rx_interface_config_reg[rtd_pkg::BIT_SINGLE] &
        rx_interface_config_reg[rtd_pkg::BIT_CLK_SEL];
    end
  end

  assign hd_single_clock = ~full_duplex & ~half_duplex_clock_submode;

  // outside half-duplex single-clock mode the pin is always driven
  always_ff @(posedge clock)
  begin
    if (srst)
    begin
      transmit_clock_pin_out <= 1'b0;
      transmit_clock_pin_oe <= 1'b0;
    end
    else
    begin
      transmit_clock_pin_out <= tx_clock_source;
      if (hd_single_clock)
        transmit_clock_pin_oe <=
          rx_interface_config_reg[rtd_pkg::BIT_TRANSMIT_CLOCK_PIN_MODE];
      else
        transmit_clock_pin_oe <= 1'b1;
    end
  end
endmodule : rtd_datapath_regs

// *** rtl/rtd_pkg.sv ***
package rtd_pkg;
  localparam logic [7:0] ADDR_RX_GAIN = 8'h38;
  localparam logic [7:0] ADDR_DBL_CTRL = 8'h39;
  localparam logic [7:0] ADDR_TX_TUNE = 8'h3a;
  localparam logic [7:0] ADDR_RX_TUNE = 8'h3b;
  localparam logic [7:0] ADDR_START_TAP = 8'h3c;
  localparam logic [7:0] ADDR_INVERT = 8'h3d;
  localparam logic [7:0] ADDR_PULSE = 8'h3e;
  localparam logic [7:0] ADDR_RX_IF = 8'h3f;

  localparam logic [7:0] MASK_RX_GAIN = 8'h1f;
  localparam logic [7:0] MASK_DBL_CTRL = 8'hc3;
  localparam logic [7:0] MASK_TUNE = 8'hff;
  localparam logic [7:0] MASK_START_TAP = 8'hff;
  localparam logic [7:0] MASK_INVERT = 8'h0f;
  localparam logic [7:0] MASK_PULSE = 8'h3f;
  localparam logic [7:0] MASK_RX_IF = 8'h78;

  localparam logic [7:0] RESET_VALUE = 8'h00;

  localparam int GAIN_W = 5;
  localparam int GAIN_FRAC = 2;
  localparam logic [4:0] UNITY_GAIN = 5'h04;

  localparam int BIT_RX_DBL_RST = 7;
  localparam int BIT_TX_DBL_RST = 6;
  localparam int BIT_RX_DBL_TYPE = 1;
  localparam int BIT_TX_DBL_TYPE = 0;
  localparam int BIT_RX_Q_NEG = 3;
  localparam int BIT_RX_I_NEG = 2;
  localparam int BIT_TX_Q_NEG = 1;
  localparam int BIT_TX_I_NEG = 0;
  localparam int TX_PULSE_HI = 5;
  localparam int TX_PULSE_LO = 3;
  localparam int RX_PULSE_HI = 2;
  localparam int RX_PULSE_LO = 0;
  localparam int BIT_CLK_SEL = 6;
  localparam int BIT_BUS_SEL = 5;
  localparam int BIT_SINGLE = 4;
  localparam int BIT_TRANSMIT_CLOCK_PIN_MODE = 3;
endpackage : rtd_pkg

// *** rtl/rtd_lane.sv ***
module rtd_lane #(
  parameter int IN_W = 12,
  parameter int OUT_W = 15
) (
  input wire logic clock,
  input wire logic srst,
  input wire logic signed [IN_W-1:0] sample,
  input wire logic negate,
  input wire logic [rtd_pkg::GAIN_W-1:0] gain_code,
  output logic signed [OUT_W-1:0] result
);
  localparam int EXT_W = IN_W + 1;
  localparam int PROD_W = EXT_W + rtd_pkg::GAIN_W + 1;

  logic signed [EXT_W-1:0] signed_sample;
  logic signed [PROD_W-1:0] product;
  logic signed [PROD_W-1:0] shifted;

  initial
  begin
    if (OUT_W < IN_W + 3)
      $error("rtd_lane: OUT_W too narrow for full gain range");
  end

  // extend first so negating the most negative code cannot wrap
  always_comb
  begin
    signed_sample = EXT_W'(sample);
    if (negate)
      signed_sample = -EXT_W'(sample);
    product = PROD_W'(signed_sample) *
      PROD_W'($signed({1'b0, gain_code}));
    shifted = product >>> rtd_pkg::GAIN_FRAC;
  end

  // fraction bits dropped by truncation toward minus infinity
  always_ff @(posedge clock)
  begin
    if (srst)
      result <= '0;
    else
      result <= OUT_W'(shifted);
  end
endmodule : rtd_lane

// *** dv/rtd_dpr_chk.sv ***
module rtd_dpr_chk #(
  parameter int RX_W = 12,
  parameter int TX_W = 12
) (
  input wire logic clock,
  input wire logic srst,
  input wire logic reg_write,
  input wire logic reg_read,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata,
  input wire logic reg_rvalid,
  input wire logic signed [TX_W-1:0] tx_i_sample,
  input wire logic signed [TX_W+2:0] i_output_converter,
  input wire logic signed [RX_W+2:0] rx_i_data,
  input wire logic signed [RX_W+2:0] rx_single_data,
  input wire logic rx_doubler_reset,
  input wire logic tx_doubler_reset,
  input wire logic rx_doubler_type,
  input wire logic tx_doubler_type,
  input wire logic single_receive_path,
  input wire logic rx_clock_from_i,
  input wire logic full_duplex,
  input wire logic half_duplex_clock_submode,
  input wire logic tx_clock_source,
  input wire logic transmit_clock_pin_out,
  input wire logic transmit_clock_pin_oe
);
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (srst);
  localparam logic [7:0] MASKS [8] = '{rtd_pkg::MASK_RX_GAIN,
    rtd_pkg::MASK_DBL_CTRL, rtd_pkg::MASK_TUNE, rtd_pkg::MASK_TUNE,
    rtd_pkg::MASK_START_TAP, rtd_pkg::MASK_INVERT, rtd_pkg::MASK_PULSE,
    rtd_pkg::MASK_RX_IF};
  // mask of the address read last cycle; unmapped reads must be all zero
  logic [7:0] lm_reg;
  always_ff @(posedge clock)
  begin
    lm_reg <= (reg_addr[7:3] == 5'h07) ? MASKS[reg_addr[2:0]] : 8'h00;
  end
  sequence quiet2;
    !reg_write [*2];
  endsequence
  sequence inv_i_on;
    reg_write && reg_addr == rtd_pkg::ADDR_INVERT && reg_wdata[0] ##1 quiet2;
  endsequence
  sequence pick_i;
    reg_write && reg_addr == rtd_pkg::ADDR_RX_IF && reg_wdata[5] ##1 quiet2;
  endsequence
  sequence float_req;
    reg_write && reg_addr == rtd_pkg::ADDR_RX_IF && !reg_wdata[3]
      ##1 (!reg_write && !full_duplex && !half_duplex_clock_submode) [*2];
  endsequence
  a_unused_read_zero: assert property (
    reg_read |=> reg_rvalid && (reg_rdata & ~lm_reg) == 8'h00)
    else $error("unused bits not zero on read");
  a_rx_dbl_rst: assert property (
    reg_write && reg_addr == rtd_pkg::ADDR_DBL_CTRL
      |-> ##2 rx_doubler_reset == $past(reg_wdata[7], 2))
    else $error("rx doubler reset wrong");
  a_tx_dbl_rst: assert property (
    reg_write && reg_addr == rtd_pkg::ADDR_DBL_CTRL
      |-> ##2 tx_doubler_reset == $past(reg_wdata[6], 2))
    else $error("tx doubler reset wrong");
  a_dbl_type: assert property (
    reg_write && reg_addr == rtd_pkg::ADDR_DBL_CTRL |-> ##2
      {rx_doubler_type, tx_doubler_type} == $past(reg_wdata[1:0], 2))
    else $error("doubler type wrong");
  a_single_cfg: assert property (
    reg_write && reg_addr == rtd_pkg::ADDR_RX_IF |-> ##2
      {single_receive_path, rx_clock_from_i} == {$past(reg_wdata[4], 2),
      $past(reg_wdata[4], 2) & $past(reg_wdata[6], 2)})
    else $error("single path config wrong");
  a_tx_i_negate: assert property (
    inv_i_on |-> i_output_converter == -$past(tx_i_sample))
    else $error("tx i not negated");
  a_single_pick_i: assert property (
    pick_i |-> rx_single_data == $past(rx_i_data))
    else $error("single path not i data");
  a_transmit_clock_pin_float: assert property (
    float_req |-> !transmit_clock_pin_oe)
    else $error("tx clock pin not floated");
  a_two_clock_drive: assert property (
    !full_duplex && half_duplex_clock_submode |=> transmit_clock_pin_oe)
    else $error("tx clock pin floated in two clock submode");
  a_pin_follow: assert property (
    transmit_clock_pin_oe |-> transmit_clock_pin_out == $past(tx_clock_source))
    else $error("tx clock pin level wrong");
endmodule : rtd_dpr_chk

bind rtd_datapath_regs rtd_dpr_chk #(.RX_W(RX_W), .TX_W(TX_W)) u_chk (.*);

// *** dv/rtd_datapath_regs_tb.sv ***
module rtd_datapath_regs_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clock = 1'b0;
  logic srst = 1'b1;
  logic reg_write = 1'b0;
  logic reg_read = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic [7:0] reg_rdata;
  logic reg_rvalid;
  logic signed [11:0] i_input_converter = 12'h000;
  logic signed [11:0] q_input_converter = 12'h000;
  logic signed [11:0] tx_i_sample = 12'h000;
  logic signed [11:0] tx_q_sample = 12'h000;
  logic signed [14:0] rx_i_data, rx_q_data, rx_single_data;
  logic signed [14:0] i_output_converter, q_output_converter;
  logic rx_doubler_reset, tx_doubler_reset, rx_doubler_type, tx_doubler_type;
  logic [7:0] tx_doubler_tuning, rx_doubler_tuning, doubler_start_tap;
  logic [2:0] tx_doubler_pulse, rx_doubler_pulse;
  logic single_receive_path, rx_clock_from_i;
  logic full_duplex = 1'b0;
  logic half_duplex_clock_submode = 1'b0;
  logic tx_clock_source = 1'b0;
  logic transmit_clock_pin_out, transmit_clock_pin_oe;
  int miscompares = 0;
  int n_tests = 0;
  int code, neg;
  logic [7:0] d, r, a8;

  rtd_datapath_regs dut (.*);

  always #12.5 clock = ~clock;
  always @(posedge clock) #2 tx_clock_source = 1'($urandom);

  task automatic tick();
    @(posedge clock);
    #2;
  endtask : tick
  task automatic chk(string n, logic [31:0] x, logic [31:0] g);
    n_tests++;
    if (g !== x)
    begin
      miscompares++;
      $display("wrong value %s expected %h seen %h", n, x, g);
    end
  endtask : chk
  // idle cycle after each strobe so a strobe is never rewritten in one step
  task automatic wr(logic [7:0] a, logic [7:0] v);
    reg_write = 1'b1;
    reg_addr = a;
    reg_wdata = v;
    tick();
    reg_write = 1'b0;
    tick();
  endtask : wr
  // read data stands for one cycle only, right after the strobe edge
  task automatic rd(logic [7:0] a, output logic [7:0] v);
    reg_read = 1'b1;
    reg_addr = a;
    tick();
    v = reg_rdata;
    reg_read = 1'b0;
    tick();
  endtask : rd
  function automatic logic [7:0] msk(logic [7:0] a);
    logic [7:0] m [8] = '{rtd_pkg::MASK_RX_GAIN, rtd_pkg::MASK_DBL_CTRL,
      rtd_pkg::MASK_TUNE, rtd_pkg::MASK_TUNE, rtd_pkg::MASK_START_TAP,
      rtd_pkg::MASK_INVERT, rtd_pkg::MASK_PULSE, rtd_pkg::MASK_RX_IF};
    return (a[7:3] == 5'h07) ? m[a[2:0]] : 8'h00;
  endfunction : msk
  // floor division by four, as an arithmetic shift on the product
  function automatic logic [31:0] scale(int s, int c, logic n);
    int v;
    v = (n ? -s : s) * c;
    return v >>> 2;
  endfunction : scale
  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : end_of_test

  initial
  begin
    #(25 * 5000);
    miscompares++;
    end_of_test();
  end

  initial
  begin
    void'($urandom(33274));
    repeat (5) @(posedge clock);
    #2;
    srst = 1'b0;
    tick();
    for (int k = 0; k < 36; k++)
    begin
      a8 = 8'h38 + 8'(k % 9);
      d = (k < 9) ? 8'h00 : (k < 18) ? 8'hff : 8'($urandom);
      if (k >= 9)
        wr(a8, d);
      rd(a8, r);
      chk("readback", d & msk(a8), r);
    end
    d = 8'($urandom);
    wr(rtd_pkg::ADDR_PULSE, d);
    wr(rtd_pkg::ADDR_START_TAP, d);
    chk("tx pulse", d[5:3], tx_doubler_pulse);
    chk("rx pulse", d[2:0], rx_doubler_pulse);
    chk("start tap", d, doubler_start_tap);
    wr(rtd_pkg::ADDR_TX_TUNE, 8'h55);
    wr(rtd_pkg::ADDR_RX_TUNE, 8'h55);
    chk("tuning", 16'h5555, {tx_doubler_tuning, rx_doubler_tuning});
    for (int k = 0; k < 40; k++)
    begin
      code = (k < 2) ? k * 31 : $urandom_range(31, 0);
      neg = $urandom_range(15, 0);
      wr(rtd_pkg::ADDR_RX_GAIN, 8'(code));
      wr(rtd_pkg::ADDR_INVERT, 8'(neg));
      i_input_converter = (k == 2) ? 12'h800 : 12'($urandom);
      q_input_converter = (k == 3) ? 12'h7ff : 12'($urandom);
      tx_i_sample = (k == 4) ? 12'h800 : 12'($urandom);
      tx_q_sample = 12'($urandom);
      tick();
      chk("rx i", scale(i_input_converter, code, neg[2]), rx_i_data);
      chk("rx q", scale(q_input_converter, code, neg[3]), rx_q_data);
      chk("dac i", scale(tx_i_sample, 4, neg[0]), i_output_converter);
      chk("dac q", scale(tx_q_sample, 4, neg[1]), q_output_converter);
    end
    for (int j = 0; j < 3; j++)
    begin
      d = (j == 0) ? 8'h70 : (j == 1) ? 8'h50 : 8'h40;
      wr(rtd_pkg::ADDR_RX_IF, d);
      chk("single mode", {d[4], d[4] & d[6]},
        {single_receive_path, rx_clock_from_i});
      chk("single data", d[5] ? scale(i_input_converter, code, neg[2]) :
        scale(q_input_converter, code, neg[3]), rx_single_data);
      tick();
    end
    for (int j = 0; j < 8; j++)
    begin
      {full_duplex, half_duplex_clock_submode} = j[1:0];
      wr(rtd_pkg::ADDR_RX_IF, {4'h0, j[2], 3'h0});
      chk("pin enable", j[2:0] != 3'h0, transmit_clock_pin_oe);
      tick();
    end
    end_of_test();
  end
endmodule : rtd_datapath_regs_tb
